// ===== rtl/pdp_pkg.sv
// shared constants for the synthesizer core and its serial load host
package pdp_pkg;

  // ------------------------------------------------------------
  // divider widths and ratio word layout
  // ------------------------------------------------------------
  localparam int SWALLOW_W = 6;
  localparam int MAIN_W = 12;
  localparam int REF_W = 14;
  localparam int RATIO_W = SWALLOW_W + MAIN_W;
  localparam int MAIN_WORD_BITS = RATIO_W + 1;
  localparam int REF_WORD_BITS = REF_W + 1;
  localparam int BITCNT_W = 5;
  localparam logic SEL_MAIN = 1'b0;
  localparam logic SEL_REF = 1'b1;

  // prescaler terminal counts: modulus 64, or 65 while swallowing
  localparam int PRE_W = 7;
  localparam logic [PRE_W-1:0] PRE_LAST_LO = 7'h3F;
  localparam logic [PRE_W-1:0] PRE_LAST_HI = 7'h40;

  // ratio latch values until the host loads them
  localparam logic [SWALLOW_W-1:0] SWALLOW_RST = 6'h00;
  localparam logic [MAIN_W-1:0] MAIN_RST = 12'h005;
  localparam logic [REF_W-1:0] REF_RST = 14'h0005;

  // ------------------------------------------------------------
  // synchroniser lanes on the core side
  // ------------------------------------------------------------
  localparam int SY_SDATA = 0;
  localparam int SY_SCLK = 1;
  localparam int SY_LE = 2;
  localparam int SY_PSN = 3;
  localparam int SY_FC = 4;
  localparam int SY_VCO = 5;
  localparam int SY_OSC = 6;
  localparam int SY_N = 7;

  // ------------------------------------------------------------
  // lock detector defaults
  // ------------------------------------------------------------
  localparam int LOCK_WIDTH_DEF = 4;
  localparam int LOCK_CYCLES_DEF = 4;

  // ------------------------------------------------------------
  // serial link timing (all minimum times)
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_MIN_NS = 1000;
  localparam int T_STEP_CYC = (T_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 9;

  // ------------------------------------------------------------
  // host register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_WORD = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;
  localparam int CTRL_PSN_BIT = 0;
  localparam int CTRL_FC_BIT = 1;
  localparam int WORD_SEL_BIT = 31;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_LOCK_BIT = 1;
  localparam logic CTRL_PSN_RST = 1'b0;
  localparam logic CTRL_FC_RST = 1'b0;

endpackage : pdp_pkg

// ===== rtl/pdp_link_if.sv
// three-wire load link plus mode and lock pins between host and core
`timescale 1ns/1ps
interface pdp_link_if;
  logic sdata;
  logic sclk;
  logic load_strobe;
  logic power_save_n;
  logic phase_sense_select;
  logic lock_indicator;

  modport host
  (
    output sdata,
    output sclk,
    output load_strobe,
    output power_save_n,
    output phase_sense_select,
    input lock_indicator
  );

  modport synth
  (
    input sdata,
    input sclk,
    input load_strobe,
    input power_save_n,
    input phase_sense_select,
    output lock_indicator
  );
endinterface : pdp_link_if

// ===== rtl/pdp_synth_core.sv
// synthesizer core: serial ratio load, dividers, phase comparator, lock detect
`timescale 1ns/1ps
module pdp_synth_core
  import pdp_pkg::*;
#(
  parameter int LOCK_WIDTH = LOCK_WIDTH_DEF,
  parameter int LOCK_CYCLES = LOCK_CYCLES_DEF
)
(
  input wire logic clk,
  input wire logic rst,
  pdp_link_if.synth link,
  input wire logic vco_in,
  input wire logic ref_osc_input,
  output logic pump_o,
  output logic pump_oe_n,
  output logic up_o,
  output logic dn_o,
  output logic dn_oe_n,
  output logic ref_phase_clk,
  output logic div_phase_clk
);

  localparam int WIDTH_CW = $clog2(LOCK_WIDTH + 1);
  localparam int GOOD_CW = $clog2(LOCK_CYCLES + 1);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [SY_N-1:0] sy1;
    logic [SY_N-1:0] sy2;
    logic [SY_N-1:0] prv;
    logic [RATIO_W-1:0] shift;
    logic ctl;
    logic [SWALLOW_W-1:0] swallow_lat;
    logic [MAIN_W-1:0] main_lat;
    logic [REF_W-1:0] ref_lat;
    logic [PRE_W-1:0] pre_cnt;
    logic [SWALLOW_W-1:0] swallow_left;
    logic [MAIN_W-1:0] main_left;
    logic [REF_W-1:0] ref_left;
    logic ref_tick;
    logic div_tick;
    logic ref_f;
    logic div_f;
    logic [WIDTH_CW-1:0] width_cnt;
    logic wide;
    logic [GOOD_CW-1:0] good_cnt;
    logic locked;
    logic lock_o;
    logic pump_o;
    logic pump_oe_n;
    logic up_o;
    logic dn_oe_n;
  } pdp_core_state_t;

  localparam pdp_core_state_t CORE_RST = '{
    sy1: '0, sy2: '0, prv: '0, shift: '0, ctl: SEL_MAIN,
    swallow_lat: SWALLOW_RST, main_lat: MAIN_RST, ref_lat: REF_RST,
    pre_cnt: '0, swallow_left: SWALLOW_RST, main_left: MAIN_RST, ref_left: REF_RST,
    ref_tick: 1'b0, div_tick: 1'b0, ref_f: 1'b0, div_f: 1'b0,
    width_cnt: '0, wide: 1'b0, good_cnt: '0, locked: 1'b0, lock_o: 1'b1,
    pump_o: 1'b0, pump_oe_n: 1'b1, up_o: 1'b0, dn_oe_n: 1'b1
  };

  pdp_core_state_t st_reg;
  pdp_core_state_t st_next;

  logic [SY_N-1:0] rise;
  logic active;
  logic fc;
  logic [PRE_W-1:0] pre_last;
  logic ref_seen;
  logic div_seen;
  logic both_seen;
  logic lead;
  logic lag;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    // pins are foreign to clk; only sy2 and later stages feed logic
    st_next.sy1 = {ref_osc_input, vco_in, link.phase_sense_select, link.power_save_n,
                   link.load_strobe, link.sclk, link.sdata};
    st_next.sy2 = st_reg.sy1;
    st_next.prv = st_reg.sy2;
    rise = st_reg.sy2 & ~st_reg.prv;
    active = st_reg.sy2[SY_PSN];
    fc = st_reg.sy2[SY_FC];

    // serial load: selector is the newest bit, ratio bits behind it
    if (rise[SY_SCLK])
    begin
      st_next.ctl = st_reg.sy2[SY_SDATA];
      st_next.shift = {st_reg.shift[RATIO_W-2:0], st_reg.ctl};
    end

    // strobe is a level: latch stays open while it is high
    if (st_reg.sy2[SY_LE] && st_reg.ctl == SEL_MAIN)
    begin
      st_next.swallow_lat = st_reg.shift[SWALLOW_W-1:0];
      st_next.main_lat = st_reg.shift[RATIO_W-1:SWALLOW_W];
    end
    if (st_reg.sy2[SY_LE] && st_reg.ctl == SEL_REF)
    begin
      st_next.ref_lat = st_reg.shift[REF_W-1:0];
    end

    // phase comparator flags, fed by the registered ticks
    ref_seen = st_reg.ref_tick | st_reg.ref_f;
    div_seen = st_reg.div_tick | st_reg.div_f;
    both_seen = ref_seen & div_seen;
    pre_last = (st_reg.swallow_left != '0) ? PRE_LAST_HI : PRE_LAST_LO;
    st_next.ref_tick = 1'b0;
    st_next.div_tick = 1'b0;

    if (!active)
    begin
      // counters held at their start values so both restart together
      st_next.pre_cnt = '0;
      st_next.swallow_left = st_reg.swallow_lat;
      st_next.main_left = st_reg.main_lat;
      st_next.ref_left = st_reg.ref_lat;
      st_next.ref_f = 1'b0;
      st_next.div_f = 1'b0;
      st_next.width_cnt = '0;
      st_next.wide = 1'b0;
    end
    else
    begin
      // reference divider
      if (rise[SY_OSC])
      begin
        st_next.ref_left = (st_reg.ref_left <= REF_W'(1)) ? st_reg.ref_lat : st_reg.ref_left - 1'b1;
        st_next.ref_tick = (st_reg.ref_left <= REF_W'(1));
      end

      // pulse-swallow divider: modulus 65 while swallow count remains, then 64
      if (rise[SY_VCO])
      begin
        st_next.pre_cnt = (st_reg.pre_cnt >= pre_last) ? '0 : st_reg.pre_cnt + 1'b1;
        if (st_reg.pre_cnt >= pre_last && st_reg.main_left <= MAIN_W'(1))
        begin
          st_next.main_left = st_reg.main_lat;
          st_next.swallow_left = st_reg.swallow_lat;
          st_next.div_tick = 1'b1;
        end
        else if (st_reg.pre_cnt >= pre_last)
        begin
          st_next.main_left = st_reg.main_left - 1'b1;
          st_next.swallow_left = st_reg.swallow_left - SWALLOW_W'(st_reg.swallow_left != '0);
        end
      end

      // a flag stands from its own edge until the other edge arrives
      st_next.ref_f = ref_seen & ~both_seen;
      st_next.div_f = div_seen & ~both_seen;

      // lock detector: a flag at the width limit marks the period wide
      st_next.width_cnt = '0;
      if (st_reg.ref_f | st_reg.div_f)
      begin
        st_next.width_cnt = (st_reg.width_cnt < WIDTH_CW'(LOCK_WIDTH)) ? st_reg.width_cnt + 1'b1 : st_reg.width_cnt;
      end
      if (st_reg.ref_tick)
      begin
        st_next.wide = 1'b0;
        if (st_reg.wide)
        begin
          // one wide pulse drops lock at once; regaining takes a run
          st_next.good_cnt = '0;
          st_next.locked = 1'b0;
        end
        else if (st_reg.good_cnt < GOOD_CW'(LOCK_CYCLES))
        begin
          st_next.good_cnt = st_reg.good_cnt + 1'b1;
        end
        else
        begin
          st_next.locked = 1'b1;
        end
      end
      // set after the per-period clear: a pulse still wide at the tick counts
      if ((st_reg.ref_f | st_reg.div_f) && st_reg.width_cnt >= WIDTH_CW'(LOCK_WIDTH))
      begin
        st_next.wide = 1'b1;
      end
    end

    // ------------------------------------------------------------
    // output drivers
    // ------------------------------------------------------------
    lead = fc ? st_reg.div_f : st_reg.ref_f;
    lag = fc ? st_reg.ref_f : st_reg.div_f;
    if (!active)
    begin
      st_next.pump_o = 1'b0;
      st_next.pump_oe_n = 1'b1;
      st_next.up_o = 1'b0;
      st_next.dn_oe_n = 1'b1;
      st_next.lock_o = 1'b1;
    end
    else
    begin
      st_next.pump_o = lead;
      st_next.pump_oe_n = ~(lead | lag);
      st_next.up_o = lag;
      st_next.dn_oe_n = ~lead;
      st_next.lock_o = st_reg.locked;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= CORE_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign pump_o = st_reg.pump_o;
  assign pump_oe_n = st_reg.pump_oe_n;
  assign up_o = st_reg.up_o;
  assign dn_o = 1'b0;
  assign dn_oe_n = st_reg.dn_oe_n;
  assign ref_phase_clk = st_reg.ref_tick;
  assign div_phase_clk = st_reg.div_tick;
  assign link.lock_indicator = st_reg.lock_o;

endmodule : pdp_synth_core

// ===== rtl/pdp_host_ctrl.sv
// host end: register port in, three-wire serial load and mode pins out
`timescale 1ns/1ps
module pdp_host_ctrl
  import pdp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  pdp_link_if.host link
);

  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_HIGH, H_LE_WAIT, H_LE} pdp_host_phase_t;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    pdp_host_phase_t phase;
    logic [TIMER_W-1:0] timer;
    logic [MAIN_WORD_BITS-1:0] word;
    logic [BITCNT_W-1:0] bits_left;
    logic sdata;
    logic sclk;
    logic le;
    logic psn;
    logic fc;
    logic lk1;
    logic lk2;
    logic [31:0] rdata;
  } pdp_host_state_t;

  localparam pdp_host_state_t HOST_RST = '{
    phase: H_IDLE, timer: '0, word: '0, bits_left: '0, sdata: 1'b0, sclk: 1'b0,
    le: 1'b0, psn: CTRL_PSN_RST, fc: CTRL_FC_RST, lk1: 1'b0, lk2: 1'b0, rdata: '0
  };

  pdp_host_state_t st_reg;
  pdp_host_state_t st_next;

  logic step_done;
  logic busy;

  always_comb
  begin
    st_next = st_reg;
    st_next.lk1 = link.lock_indicator;
    st_next.lk2 = st_reg.lk1;
    busy = (st_reg.phase != H_IDLE);
    step_done = (st_reg.timer == TIMER_W'(T_STEP_CYC - 1));
    st_next.timer = step_done ? '0 : st_reg.timer + 1'b1;

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    st_next.rdata = '0;
    if (rd)
    begin
      case (addr)
        REG_CTRL:
        begin
          st_next.rdata[CTRL_PSN_BIT] = st_reg.psn;
          st_next.rdata[CTRL_FC_BIT] = st_reg.fc;
        end
        REG_STATUS:
        begin
          st_next.rdata[STAT_BUSY_BIT] = busy;
          st_next.rdata[STAT_LOCK_BIT] = st_reg.lk2;
        end
        default: st_next.rdata = '0;
      endcase
    end
    if (wr && addr == REG_CTRL)
    begin
      st_next.psn = wdata[CTRL_PSN_BIT];
      st_next.fc = wdata[CTRL_FC_BIT];
    end

    // ------------------------------------------------------------
    // serial sequencer, msb first, selector bit sent last
    // ------------------------------------------------------------
    case (st_reg.phase)
      H_IDLE:
      begin
        st_next.timer = '0;
        if (wr && addr == REG_WORD)
        begin
          st_next.phase = H_SETUP;
          if (wdata[WORD_SEL_BIT] == SEL_REF)
          begin
            st_next.word = {wdata[REF_W-1:0], SEL_REF, (RATIO_W - REF_W)'(0)};
            st_next.bits_left = BITCNT_W'(REF_WORD_BITS);
          end
          else
          begin
            st_next.word = {wdata[RATIO_W-1:0], SEL_MAIN};
            st_next.bits_left = BITCNT_W'(MAIN_WORD_BITS);
          end
          st_next.sdata = st_next.word[MAIN_WORD_BITS-1];
        end
      end
      H_SETUP:
      begin
        if (step_done)
        begin
          st_next.sclk = 1'b1;
          st_next.phase = H_HIGH;
        end
      end
      H_HIGH:
      begin
        if (step_done)
        begin
          st_next.sclk = 1'b0;
          st_next.word = {st_reg.word[MAIN_WORD_BITS-2:0], 1'b0};
          st_next.sdata = st_reg.word[MAIN_WORD_BITS-2];
          st_next.bits_left = st_reg.bits_left - 1'b1;
          st_next.phase = (st_reg.bits_left == BITCNT_W'(1)) ? H_LE_WAIT : H_SETUP;
        end
      end
      H_LE_WAIT:
      begin
        if (step_done)
        begin
          st_next.le = 1'b1;
          st_next.phase = H_LE;
        end
      end
      H_LE:
      begin
        if (step_done)
        begin
          st_next.le = 1'b0;
          st_next.sdata = 1'b0;
          st_next.phase = H_IDLE;
        end
      end
      default: st_next.phase = H_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= HOST_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;
  assign link.sdata = st_reg.sdata;
  assign link.sclk = st_reg.sclk;
  assign link.load_strobe = st_reg.le;
  assign link.power_save_n = st_reg.psn;
  assign link.phase_sense_select = st_reg.fc;

endmodule : pdp_host_ctrl

// ===== testbench/pdp_link_asserts.sv
// assertion checker for the load link between host and core
`timescale 1ns/1ps
module pdp_link_asserts
  import pdp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sdata,
  input wire logic sclk,
  input wire logic load_strobe,
  input wire logic power_save_n,
  input wire logic phase_sense_select,
  input wire logic lock_indicator
);
  // ------------------------------------------------------------
  // helper counters
  // ------------------------------------------------------------
  logic [9:0] hi_reg, lo_reg, st_reg;
  logic [5:0] bits_reg;
  logic sclk_reg, last_reg;

  // saturating, so long idle spans never wrap back below the limit
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hi_reg <= 10'h000;
      lo_reg <= 10'h000;
      st_reg <= 10'h000;
      bits_reg <= 6'h00;
      sclk_reg <= 1'b0;
      last_reg <= 1'b0;
    end
    else
    begin
      hi_reg <= sclk ? hi_reg + 10'(hi_reg != 10'h3FF) : 10'h000;
      lo_reg <= !sclk ? lo_reg + 10'(lo_reg != 10'h3FF) : 10'h000;
      st_reg <= load_strobe ? st_reg + 10'(st_reg != 10'h3FF) : 10'h000;
      sclk_reg <= sclk;
      if (load_strobe)
        bits_reg <= 6'h00;
      else if (sclk && !sclk_reg)
        bits_reg <= bits_reg + 6'h01;
      if (sclk && !sclk_reg)
        last_reg <= sdata;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_lock_in_save;
    (!power_save_n) [*6] |-> lock_indicator;
  endproperty
  a_lock_in_save: assert property (p_lock_in_save)
    else $error("lock indicator low in power save");

  property p_sdata_moves_low;
    $changed(sdata) |-> !sclk;
  endproperty
  a_sdata_moves_low: assert property (p_sdata_moves_low)
    else $error("serial data moved while serial clock high");

  property p_sclk_high_width;
    $fell(sclk) |-> hi_reg >= T_STEP_CYC;
  endproperty
  a_sclk_high_width: assert property (p_sclk_high_width)
    else $error("serial clock high pulse too short");

  property p_sclk_low_width;
    $rose(sclk) |-> lo_reg >= T_STEP_CYC;
  endproperty
  a_sclk_low_width: assert property (p_sclk_low_width)
    else $error("serial data setup too short");

  property p_no_shift_in_strobe;
    load_strobe |-> !$rose(sclk);
  endproperty
  a_no_shift_in_strobe: assert property (p_no_shift_in_strobe)
    else $error("serial clock rose during load strobe");

  property p_strobe_setup;
    $rose(load_strobe) |-> !sclk && lo_reg >= T_STEP_CYC;
  endproperty
  a_strobe_setup: assert property (p_strobe_setup)
    else $error("load strobe too close to last serial clock");

  property p_strobe_width;
    $fell(load_strobe) |-> st_reg >= T_STEP_CYC;
  endproperty
  a_strobe_width: assert property (p_strobe_width)
    else $error("load strobe pulse too short");

  property p_word_main;
    $rose(load_strobe) && last_reg == SEL_MAIN |-> bits_reg == MAIN_WORD_BITS;
  endproperty
  a_word_main: assert property (p_word_main)
    else $error("main word bit count wrong");

  property p_word_ref;
    $rose(load_strobe) && last_reg == SEL_REF |-> bits_reg == REF_WORD_BITS;
  endproperty
  a_word_ref: assert property (p_word_ref)
    else $error("reference word bit count wrong");
endmodule : pdp_link_asserts

// ===== testbench/pdp_tb_top.sv
// self-checking bench: host controller driving the synthesizer core
`timescale 1ns/1ps
module pdp_tb_top
  import pdp_pkg::*;
;
  logic clk, rst, wr, rd, vco_in, ref_osc_input, ph, vco_run, mon, drv_seen;
  logic pump_o, pump_oe_n, up_o, dn_o, dn_oe_n, ref_phase_clk, div_phase_clk;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wdata, rdata, seed, d;
  logic [1:0] cyc;
  int errors, compares, vco_rises, osc_rises, r1, n1, a1, k;

  pdp_link_if i_pdp_link_if ();
  pdp_host_ctrl i_pdp_host_ctrl (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .link(i_pdp_link_if.host));
  pdp_synth_core i_pdp_synth_core (.clk(clk), .rst(rst), .link(i_pdp_link_if.synth), .vco_in(vco_in),
    .ref_osc_input(ref_osc_input), .pump_o(pump_o), .pump_oe_n(pump_oe_n), .up_o(up_o), .dn_o(dn_o),
    .dn_oe_n(dn_oe_n), .ref_phase_clk(ref_phase_clk), .div_phase_clk(div_phase_clk));
  pdp_link_asserts i_pdp_link_asserts (.clk(clk), .rst(rst), .sdata(i_pdp_link_if.sdata),
    .sclk(i_pdp_link_if.sclk), .load_strobe(i_pdp_link_if.load_strobe),
    .power_save_n(i_pdp_link_if.power_save_n), .phase_sense_select(i_pdp_link_if.phase_sense_select),
    .lock_indicator(i_pdp_link_if.lock_indicator));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ------------------------------------------------------------
  // divider inputs: period of six clocks, inputs must stay below clk/4
  // ------------------------------------------------------------
  always @(posedge clk)
  begin
    cyc <= (cyc == 2'h2) ? 2'h0 : cyc + 2'h1;
    if (mon && pump_oe_n !== 1'b1)
      drv_seen <= 1'b1;
    if (cyc == 2'h2)
    begin
      ph <= ~ph;
      ref_osc_input <= ~ph;
      vco_in <= ~ph & vco_run;
      if (!ph)
        osc_rises <= osc_rises + 1;
      if (!ph && vco_run)
        vco_rises <= vco_rises + 1;
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic int f_ratio(input int n, input int a);
    return 64 * n + a;
  endfunction : f_ratio

  function automatic logic [31:0] f_word(input logic sel, input int n, input int a);
    return sel ? {sel, 17'h0_0000, 14'(n)} : {sel, 13'h0000, 12'(n), 6'(a)};
  endfunction : f_word

  task automatic complete_run;
    if (errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg

  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [31:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask : rd_reg

  // busy polling with a bound; a word takes about ten thousand clocks
  task automatic wait_idle;
    logic [31:0] s;
    int n;
    n = 0;
    do
    begin
      repeat (50) @(posedge clk);
      rd_reg(REG_STATUS, s);
      n++;
    end
    while (s[STAT_BUSY_BIT] !== 1'b0 && n < 400);
    chk("busy clears", 32'(s[STAT_BUSY_BIT]), 32'h0000_0000);
  endtask : wait_idle

  task automatic wait_tick(input bit is_ref);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while ((is_ref ? ref_phase_clk : div_phase_clk) !== 1'b1 && n < 20000);
    chk("tick seen", 32'(n >= 20000), 32'h0000_0000);
  endtask : wait_tick

  task automatic meas(input bit is_ref, input int exp, input string nm);
    int s;
    wait_tick(is_ref);
    s = is_ref ? osc_rises : vco_rises;
    wait_tick(is_ref);
    chk(nm, 32'((is_ref ? osc_rises : vco_rises) - s), 32'(exp));
  endtask : meas

  task automatic pins(input logic [3:0] e);
    chk("oe up dn lock", 32'({pump_oe_n, up_o, dn_oe_n, i_pdp_link_if.lock_indicator}), 32'(e));
  endtask : pins

  initial
  begin
    // four words and the divider periods need about 70000 clocks
    repeat (90000) @(posedge clk);
    errors++;
    complete_run;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    {rst, wr, rd, addr, wdata, vco_in, ref_osc_input, ph, cyc, mon, drv_seen} = '0;
    rst = 1'b1;
    vco_run = 1'b1;
    {errors, compares, vco_rises, osc_rises} = '0;
    seed = 32'h8676_7386;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_reg(REG_CTRL, d);
    chk("ctrl reset", d, 32'h0000_0000);
    rd_reg(REG_STATUS, d);
    chk("status reset", d, 32'h0000_0002);
    rd_reg(4'hC, d);
    chk("unmapped read", d, 32'h0000_0000);
    pins(4'hB);
    wr_reg(REG_CTRL, 32'h0000_0001);
    seed = lfsr(lfsr(seed));
    r1 = 5 + int'(seed[2:0]);
    n1 = 5 + int'(seed[8]);
    a1 = int'(seed[13:9]) % n1;
    wr_reg(REG_WORD, f_word(SEL_REF, r1, 0));
    wait_idle;
    wr_reg(REG_WORD, f_word(SEL_MAIN, n1, a1));
    rd_reg(REG_STATUS, d);
    chk("busy after word", 32'(d[STAT_BUSY_BIT]), 32'h0000_0001);
    // write while busy must be dropped
    wr_reg(REG_WORD, f_word(SEL_MAIN, 7, 6));
    wait_idle;
    meas(1'b1, r1, "ref ratio");
    meas(1'b0, f_ratio(n1, a1), "div ratio");
    wr_reg(REG_WORD, f_word(SEL_MAIN, 5, 4));
    wait_idle;
    meas(1'b0, f_ratio(5, 4), "div ratio edge");
    meas(1'b1, r1, "ref kept");
    // divider input stopped, so the reference always leads
    vco_run <= 1'b0;
    for (k = 0; k < 3; k++)
      wait_tick(1'b1);
    repeat (4) @(posedge clk);
    chk("pump sense low", 32'(pump_o), 32'h0000_0001);
    pins(4'h0);
    chk("down level", 32'(dn_o), 32'h0000_0000);
    wr_reg(REG_CTRL, 32'h0000_0003);
    repeat (8) @(posedge clk);
    chk("pump sense high", 32'(pump_o), 32'h0000_0000);
    pins(4'h6);
    rd_reg(REG_CTRL, d);
    chk("ctrl readback", d, 32'h0000_0003);
    rd_reg(REG_STATUS, d);
    chk("lock status", 32'(d[STAT_LOCK_BIT]), 32'h0000_0000);
    wr_reg(REG_WORD, f_word(SEL_REF, f_ratio(5, 4), 0));
    wait_idle;
    wr_reg(REG_CTRL, 32'h0000_0000);
    repeat (8) @(posedge clk);
    pins(4'hB);
    vco_run <= 1'b1;
    k = 0;
    repeat (3000)
    begin
      @(posedge clk);
      k += int'(ref_phase_clk === 1'b1);
    end
    chk("ticks in save", 32'(k), 32'h0000_0000);
    wr_reg(REG_CTRL, 32'h0000_0001);
    k = 0;
    while (ref_phase_clk !== 1'b1 && div_phase_clk !== 1'b1 && k < 20000)
    begin
      @(posedge clk);
      k++;
    end
    chk("wake tick seen", 32'(k >= 20000), 32'h0000_0000);
    chk("aligned ticks", 32'(div_phase_clk), 32'(ref_phase_clk));
    mon <= 1'b1;
    for (k = 0; k < 7; k++)
      wait_tick(1'b1);
    chk("no pump pulse", 32'(drv_seen), 32'h0000_0000);
    chk("lock after wake", 32'(i_pdp_link_if.lock_indicator), 32'h0000_0001);
    complete_run;
  end
endmodule : pdp_tb_top
